// ---- dv/link_host_model.sv ----
// link_host_model: host side of the fault bank link, one command at a time
// assumes the bank answers every taken request with a one-cycle done pulse
`timescale 1ns/1ns
`default_nettype none
module link_host_model
  import fault_bank_pkg::*;
(
  // link
  input wire logic LINK_CLK_I,
  input wire logic LINK_DONE_I,
  input wire logic [15:0] LINK_RDATA_I,
  output logic LINK_REQ_O,
  output link_req_s LINK_CMD_O
);
  // idle at time zero
  initial begin
    LINK_REQ_O = 1'b0;
    LINK_CMD_O = '0;
  end
  // request held until done is seen; a missing answer returns unknowns
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] r);
    int n;
    n = 0;
    r = 16'hxxxx;
    @(posedge LINK_CLK_I);
    #2;
    LINK_REQ_O = 1'b1;
    LINK_CMD_O = '{write: w, cmd: c, data: d};
    while (n < 40) begin
      @(posedge LINK_CLK_I);
      #2;
      n++;
      if (LINK_DONE_I === 1'b1) begin
        r = LINK_RDATA_I;
        n = 99;
      end
    end
    LINK_REQ_O = 1'b0;
    // released command lines do not keep their last value
    LINK_CMD_O = ~LINK_CMD_O;
  endtask : xfer
endmodule : link_host_model
`default_nettype wire

// ---- dv/pmbus_fault_status_bank_tb.sv ----
// pmbus_fault_status_bank_tb: self-checking bench for the fault status bank
// assumes the package, defines header and link host model compile first
`timescale 1ns/1ns
`default_nettype none
`include "fault_bank_defines.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
  $display("Error t=%0t got=%h exp=%h", $time, a, b); end end
module pmbus_fault_status_bank_tb;
  import fault_bank_pkg::*;
  logic sys_clk, link_clk, arst_n, link_req, link_busy, link_done, alert_n;
  fault_event_s ev;
  alert_mask_s mask;
  live_pins_s live;
  link_req_s link_cmd;
  logic [15:0] link_rdata, rd;
  logic [7:0] exp [5];
  logic busy, unk;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  localparam logic [7:0] SUPP [5] = '{`SUPP_VOUT, `SUPP_IOUT, `SUPP_INPUT, `SUPP_TEMP, `SUPP_CML};
  // clocks, link clock unrelated in phase
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    link_clk = 1'b0;
    #13;
    forever #40 link_clk = ~link_clk;
  end
  pmbus_fault_status_bank dut (.SYS_CLK_I(sys_clk), .ARST_N_I(arst_n), .EVENT_I(ev),
    .MASK_I(mask), .LIVE_I(live), .LINK_CLK_I(link_clk), .LINK_REQ_I(link_req),
    .LINK_CMD_I(link_cmd), .LINK_BUSY_O(link_busy), .LINK_DONE_O(link_done),
    .LINK_RDATA_O(link_rdata), .ALERT_N_O(alert_n));
  link_host_model host (.LINK_CLK_I(link_clk), .LINK_DONE_I(link_done),
    .LINK_RDATA_I(link_rdata), .LINK_REQ_O(link_req), .LINK_CMD_O(link_cmd));
  // expected summary byte, word and detailed registers
  function automatic logic [7:0] byte_exp();
    return {busy, live.not_converting, exp[0][7], exp[1][7], 1'b0, |exp[3], |exp[4], unk};
  endfunction : byte_exp
  function automatic logic [15:0] word_exp();
    return {|exp[0], |exp[1], |exp[2], live.mfr_fault, live.pgood_bad, 1'b0,
      live.other_fault, 1'b0, byte_exp()};
  endfunction : word_exp
  function automatic logic [15:0] reg_exp(int i);
    return {8'h00, exp[i] | ((i == 2) ? {4'h0, live.input_too_low, 3'h0} : 8'h00)};
  endfunction : reg_exp
  // one-cycle event pulse; waits first so live levels are synced
  task automatic fire(input fault_event_s e);
    repeat (4) @(posedge sys_clk);
    #2;
    ev = e;
    @(posedge sys_clk);
    #2;
    ev = '0;
    exp[0] |= e.vout & SUPP[0];
    exp[1] |= e.iout & SUPP[1];
    exp[2] |= e.inp & SUPP[2];
    exp[3] |= e.temp & SUPP[3];
    exp[4] |= (e.cml & SUPP[4]) | {6'h00, e.backchan_err & live.follower, 1'b0};
    busy |= e.busy;
    unk |= e.unlisted_fault_flag;
  endtask : fire
  task automatic check_all();
    int i;
    for (i = 0; i < 5; i++) begin
      host.xfer(1'b0, `CMD_VOUT + 8'(i), 16'h0000, rd);
      `CHK(rd, reg_exp(i))
    end
    host.xfer(1'b0, `CMD_SUM_WORD, 16'h0000, rd);
    `CHK(rd, word_exp())
    host.xfer(1'b0, `CMD_SUM_BYTE, 16'h0000, rd);
    `CHK({link_busy, rd}, {1'b0, 8'h00, byte_exp()})
  endtask : check_all
  task automatic alert_chk(input logic v);
    repeat (6) @(posedge sys_clk);
    #2;
    `CHK(alert_n, v)
  endtask : alert_chk
  task automatic clr_all();
    host.xfer(1'b1, `CMD_CLEAR_ALL, 16'h0000, rd);
    for (int i = 0; i < 5; i++) exp[i] = 8'h00;
    busy = 1'b0;
    unk = 1'b0;
  endtask : clr_all
  task complete_run();
    if (err_total == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    fault_event_s e;
    logic [7:0] w;
    logic [15:0] wv;
    int k, i;
    void'($urandom(32'h6fe7));
    arst_n = 1'b0;
    ev = '0;
    mask = '0;
    live = '0;
    live.input_too_low = 1'b1;
    live.follower = 1'b1;
    busy = 1'b0;
    unk = 1'b0;
    for (i = 0; i < 5; i++) exp[i] = 8'h00;
    repeat (16) @(posedge sys_clk);
    #2;
    arst_n = 1'b1;
    check_all();
    alert_chk(1'b1);
    // undervolt warning held off until input first seen above turn-on
    e = '0;
    e.inp = 8'h20;
    fire(e);
    alert_chk(1'b1);
    live.above_on = 1'b1;
    alert_chk(1'b0);
    mask.inp = 8'h20;
    alert_chk(1'b1);
    // overvolt alert gated by per-source and common masks
    e = '0;
    e.vout = 8'h80;
    e.ovp_src = 3'b001;
    mask.ext_ovp = 3'b001;
    fire(e);
    alert_chk(1'b1);
    mask.ext_ovp = 3'b000;
    alert_chk(1'b0);
    mask.vout = 8'h80;
    alert_chk(1'b1);
    clr_all();
    mask = '0;
    alert_chk(1'b1);
    // back-channel errors count only when operating as follower
    live.follower = 1'b0;
    e = '0;
    e.backchan_err = 1'b1;
    fire(e);
    check_all();
    for (k = 0; k < 12; k++) begin
      live = $bits(live_pins_s)'($urandom);
      live.follower = 1'b1;
      live.above_on = 1'b1;
      mask = $bits(alert_mask_s)'({$urandom, $urandom});
      e = $bits(fault_event_s)'({$urandom, $urandom});
      if (k == 0) e = '1;
      fire(e);
      check_all();
      for (i = 0; i < 5; i++) begin
        w = (k == 1) ? 8'hff : (k == 2) ? 8'h00 : 8'($urandom);
        host.xfer(1'b1, `CMD_VOUT + 8'(i), {8'h00, w}, rd);
        `CHK(rd, reg_exp(i))
        exp[i] &= ~w;
      end
      wv = (k % 3 == 2) ? 16'($urandom) & 16'hff7f : (k % 3 == 0) ? `CLR_BUSY_WORD : `CLR_BUSY_UNK_WORD;
      host.xfer(1'b1, `CMD_SUM_WORD, wv, rd);
      if (k % 3 == 2) host.xfer(1'b1, `CMD_SUM_BYTE, {8'h00, `CLR_BUSY_BYTE}, rd);
      if (wv == `CLR_BUSY_WORD || wv == `CLR_BUSY_UNK_WORD || k % 3 == 2) busy = 1'b0;
      if (wv == `CLR_BUSY_UNK_WORD) unk = 1'b0;
      check_all();
      host.xfer(1'b1, `CMD_SUM_WORD, `CLR_BUSY_UNK_WORD, rd);
      busy = 1'b0;
      unk = 1'b0;
      clr_all();
      check_all();
    end
    complete_run();
  end
endmodule : pmbus_fault_status_bank_tb
`default_nettype wire

// ---- rtl/fault_bank_defines.svh ----
// fault_bank_defines.svh: command codes, bit positions and reset values
// assumes plain 8-bit command codes and 16-bit data as carried by the link
`ifndef FAULT_BANK_DEFINES_SVH
`define FAULT_BANK_DEFINES_SVH
// command codes
`define CMD_CLEAR_ALL 8'h03
`define CMD_SUM_BYTE 8'h78
`define CMD_SUM_WORD 8'h79
`define CMD_VOUT 8'h7a
`define CMD_IOUT 8'h7b
`define CMD_INPUT 8'h7c
`define CMD_TEMP 8'h7d
`define CMD_CML 8'h7e
// latched flags that exist in each detailed register
`define SUPP_VOUT 8'hfc
`define SUPP_IOUT 8'ha0
`define SUPP_INPUT 8'ha0
`define SUPP_TEMP 8'hc0
`define SUPP_CML 8'hfa
// special write values on the summary registers
`define CLR_BUSY_BYTE 8'h80
`define CLR_BUSY_WORD 16'h0080
`define CLR_BUSY_UNK_WORD 16'h0180
// bit positions
`define BIT_OVF 7
`define BIT_UVW 5
`define BIT_LOWVIN 3
`define BIT_COMMUNICATION_ERROR_FLAG 1
`define BIT_BUSY 7
`define BIT_UNK 0
// live pin reset state: input-too-low is high
`define LIVE_RST 7'h01
`define ZERO8 8'h00
`define ZERO16 16'h0000
`endif

// ---- rtl/fault_bank_pkg.sv ----
// fault_bank_pkg: types shared by the fault status bank
// assumes the defines header is compiled alongside
package fault_bank_pkg;
  // one link transaction
  typedef struct packed {
    logic write;
    logic [7:0] cmd;
    logic [15:0] data;
  } link_req_s;
  // fault events, one-cycle pulses from detectors on the system clock
  typedef struct packed {
    logic [7:0] vout;
    logic [2:0] ovp_src;
    logic [7:0] iout;
    logic [7:0] inp;
    logic [7:0] temp;
    logic [7:0] cml;
    logic backchan_err;
    logic busy;
    logic unlisted_fault_flag;
  } fault_event_s;
  // alert masks, one bit per alert-capable status bit, plus one per extended overvolt source
  typedef struct packed {
    logic [7:0] sum_byte;
    logic [7:0] vout;
    logic [2:0] ext_ovp;
    logic [7:0] iout;
    logic [7:0] inp;
    logic [7:0] temp;
    logic [7:0] cml;
  } alert_mask_s;
  // asynchronous live levels from pins
  typedef struct packed {
    logic follower;
    logic other_fault;
    logic mfr_fault;
    logic pgood_bad;
    logic not_converting;
    logic above_on;
    logic input_too_low;
  } live_pins_s;
endpackage : fault_bank_pkg

// ---- rtl/pmbus_fault_status_bank.sv ----
// pmbus_fault_status_bank: summary and detailed fault status registers
// assumes a transaction layer on LINK_CLK_I hands over decoded commands
// Operation
// - word bit 9 shows other-register fault
// - unsupported bits always read zero
// - word low byte equals summary byte
// - writing 0080h to word clears busy
// - writing 0180h clears busy and unlisted_fault_flag
// - clear-all or write-one clears latched flags
// - output voltage latched flags bits 7..2
// - overvolt mask covers three sources, extended
// - overcurrent fault bit7, warning bit5
// - input overvolt fault 7, undervolt warn 5
// - input bit 3 live low-input indication
// - low input set at reset, never alerts
// - undervolt warn alert masked until turn-on
// - overtemp fault bit7, warning bit6
// - communication_error_flag/logic flags latched at bits 7..3,1
// - masked status bits never drive alert
// - follower back-channel errors flag communication_error_flag error
// - communication_error_flag summary is OR of its flags
// - byte busy bit7, communication_error_flag summary bit1
// - word bits 15..13 point to registers
`timescale 1ns/1ns
`default_nettype none
`include "fault_bank_defines.svh"
module pmbus_fault_status_bank
  import fault_bank_pkg::*;
(
  // system side
  input wire logic SYS_CLK_I,
  input wire logic ARST_N_I,
  input wire fault_event_s EVENT_I,
  input wire alert_mask_s MASK_I,
  input wire live_pins_s LIVE_I,
  // link side, on its own clock
  input wire logic LINK_CLK_I,
  input wire logic LINK_REQ_I,
  input wire link_req_s LINK_CMD_I,
  output logic LINK_BUSY_O,
  output logic LINK_DONE_O,
  output logic [15:0] LINK_RDATA_O,
  // alert line, low while any unmasked flag is set; overvolt fault needs an unmasked source, undervolt warn needs turn-on
  output logic ALERT_N_O
);

  // set wins over clear for every latched flag
  // so an event landing in a clear cycle is never lost
  function automatic logic [7:0] upd(input logic [7:0] f, input logic [7:0] s,
                                     input logic [7:0] c, input logic [7:0] supp);
    upd = ((f & ~c) | s) & supp;
  endfunction : upd

  // link domain: capture request, toggle towards system domain
  link_req_s req_hold;
  logic req_tgl;
  logic ack_s1;
  logic ack_s2;
  logic ack_s3;
  logic [15:0] rdata_hold;
  logic ack_tgl;

  // request capture, refused while one is in flight
  always_ff @(posedge LINK_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      req_hold <= '0;
      req_tgl <= 1'b0;
    end else if (LINK_REQ_I && !LINK_BUSY_O) begin
      req_hold <= LINK_CMD_I;
      req_tgl <= ~req_tgl;
    end
  end

  // ack toggle synchroniser; stages two and three feed the edge detect
  always_ff @(posedge LINK_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_s3 <= 1'b0;
    end else begin
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
    end
  end

  // busy, done pulse and read data; rdata_hold is stable once ack is seen
  // a request raised while busy is dropped without any indication
  always_ff @(posedge LINK_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      LINK_BUSY_O <= 1'b0;
      LINK_DONE_O <= 1'b0;
      LINK_RDATA_O <= `ZERO16;
    end else begin
      LINK_DONE_O <= ack_s2 ^ ack_s3;
      if (ack_s2 ^ ack_s3) begin
        LINK_BUSY_O <= 1'b0;
        LINK_RDATA_O <= rdata_hold;
      end else if (LINK_REQ_I) begin
        LINK_BUSY_O <= 1'b1;
      end
    end
  end

  // system domain: request toggle synchroniser
  logic req_s1;
  logic req_s2;
  logic req_s3;
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
    end else begin
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
    end
  end

  // request fields are held still by the link side until ack returns
  logic go;
  logic wr;
  assign go = req_s2 ^ req_s3;
  assign wr = go && req_hold.write;

  // live pins: two flops; low input starts set
  // resetting it high keeps the input reading off until the pins settle
  live_pins_s live_s1;
  live_pins_s live;
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      live_s1 <= `LIVE_RST;
      live <= `LIVE_RST;
    end else begin
      live_s1 <= LIVE_I;
      live <= live_s1;
    end
  end

  // write decode; clear-all is a bare command
  logic clr_all;
  logic [7:0] c_vout;
  logic [7:0] c_iout;
  logic [7:0] c_inp;
  logic [7:0] c_temp;
  logic [7:0] c_cml;
  logic clr_busy;
  logic clr_unk;
  assign clr_all = go && req_hold.cmd == `CMD_CLEAR_ALL;
  assign c_vout = (wr && req_hold.cmd == `CMD_VOUT) || clr_all ?
                  (clr_all ? 8'hff : req_hold.data[7:0]) : `ZERO8;
  assign c_iout = (wr && req_hold.cmd == `CMD_IOUT) || clr_all ?
                  (clr_all ? 8'hff : req_hold.data[7:0]) : `ZERO8;
  assign c_inp = (wr && req_hold.cmd == `CMD_INPUT) || clr_all ?
                 (clr_all ? 8'hff : req_hold.data[7:0]) : `ZERO8;
  assign c_temp = (wr && req_hold.cmd == `CMD_TEMP) || clr_all ?
                  (clr_all ? 8'hff : req_hold.data[7:0]) : `ZERO8;
  assign c_cml = (wr && req_hold.cmd == `CMD_CML) || clr_all ?
                 (clr_all ? 8'hff : req_hold.data[7:0]) : `ZERO8;
  // exact values only; other summary writes are ignored
  assign clr_busy = clr_all
    || (wr && req_hold.cmd == `CMD_SUM_BYTE && req_hold.data[7:0] == `CLR_BUSY_BYTE)
    || (wr && req_hold.cmd == `CMD_SUM_WORD && req_hold.data == `CLR_BUSY_WORD)
    || (wr && req_hold.cmd == `CMD_SUM_WORD && req_hold.data == `CLR_BUSY_UNK_WORD);
  assign clr_unk = clr_all
    || (wr && req_hold.cmd == `CMD_SUM_WORD && req_hold.data == `CLR_BUSY_UNK_WORD);

  // follower reports back-channel trouble as its own communication_error_flag error
  logic [7:0] cml_set;
  always_comb begin
    cml_set = EVENT_I.cml;
    if (live.follower && EVENT_I.backchan_err) begin
      cml_set[`BIT_COMMUNICATION_ERROR_FLAG] = 1'b1;
    end
  end

  // detailed latched registers; unsupported bits masked to zero
  logic [7:0] vout;
  logic [7:0] iout;
  logic [7:0] inp;
  logic [7:0] temp;
  logic [7:0] cml;
  logic [2:0] ovp_seen;
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      vout <= `ZERO8;
      iout <= `ZERO8;
      inp <= `ZERO8;
      temp <= `ZERO8;
      cml <= `ZERO8;
    end else begin
      vout <= upd(vout, EVENT_I.vout, c_vout, `SUPP_VOUT);
      iout <= upd(iout, EVENT_I.iout, c_iout, `SUPP_IOUT);
      inp <= upd(inp, EVENT_I.inp, c_inp, `SUPP_INPUT);
      temp <= upd(temp, EVENT_I.temp, c_temp, `SUPP_TEMP);
      cml <= upd(cml, cml_set, c_cml, `SUPP_CML);
    end
  end

  // which overvolt sources fired; cleared with the fault flag
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ovp_seen <= 3'h0;
    end else if (c_vout[`BIT_OVF] && ~|EVENT_I.ovp_src) begin
      ovp_seen <= 3'h0;
    end else begin
      ovp_seen <= ovp_seen | EVENT_I.ovp_src;
    end
  end

  // busy and unlisted_fault_flag summary flags
  logic busy;
  logic unlisted_fault_flag;
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      busy <= 1'b0;
      unlisted_fault_flag <= 1'b0;
    end else begin
      busy <= EVENT_I.busy | (busy & ~clr_busy);
      unlisted_fault_flag <= EVENT_I.unlisted_fault_flag | (unlisted_fault_flag & ~clr_unk);
    end
  end

  // undervolt warning alert held off until input first passes turn-on
  // sticky until reset: a later dip does not re-arm the hold-off
  logic vin_seen_on;
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      vin_seen_on <= 1'b0;
    end else if (live.above_on) begin
      vin_seen_on <= 1'b1;
    end
  end

  // readback values
  logic [7:0] sum_byte;
  logic [15:0] sum_word;
  logic [7:0] inp_rd;
  always_comb begin
    inp_rd = inp;
    inp_rd[`BIT_LOWVIN] = live.input_too_low;
    sum_byte = {busy, live.not_converting, vout[`BIT_OVF], iout[`BIT_OVF], 1'b0,
                |temp, |cml, unlisted_fault_flag};
    sum_word = {|vout, |iout, |inp, live.mfr_fault, live.pgood_bad, 1'b0,
                live.other_fault, 1'b0, sum_byte};
  end

  // read mux; unmapped codes answer zero
  logic [15:0] rd_mux;
  always_comb begin
    unique case (req_hold.cmd)
      `CMD_SUM_BYTE: rd_mux = {`ZERO8, sum_byte};
      `CMD_SUM_WORD: rd_mux = sum_word;
      `CMD_VOUT: rd_mux = {`ZERO8, vout};
      `CMD_IOUT: rd_mux = {`ZERO8, iout};
      `CMD_INPUT: rd_mux = {`ZERO8, inp_rd};
      `CMD_TEMP: rd_mux = {`ZERO8, temp};
      `CMD_CML: rd_mux = {`ZERO8, cml};
      default: rd_mux = `ZERO16;
    endcase
  end

  // answer: snapshot taken before this request's own effect lands
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rdata_hold <= `ZERO16;
      ack_tgl <= 1'b0;
    end else if (go) begin
      rdata_hold <= rd_mux;
      ack_tgl <= ~ack_tgl;
    end
  end

  // alert terms; the live low-input bit is left out on purpose
  logic ovf_alert;
  logic uvw_alert;
  logic [7:0] vout_alert;
  logic [7:0] inp_alert;
  logic any_alert;
  always_comb begin
    ovf_alert = vout[`BIT_OVF] && !MASK_I.vout[`BIT_OVF]
                && |(ovp_seen & ~MASK_I.ext_ovp);
    vout_alert = vout & ~MASK_I.vout;
    vout_alert[`BIT_OVF] = ovf_alert;
    uvw_alert = inp[`BIT_UVW] && !MASK_I.inp[`BIT_UVW] && vin_seen_on;
    inp_alert = inp & ~MASK_I.inp;
    inp_alert[`BIT_UVW] = uvw_alert;
    any_alert = |vout_alert || |inp_alert || |(iout & ~MASK_I.iout)
      || |(temp & ~MASK_I.temp) || |(cml & ~MASK_I.cml)
      || (busy && !MASK_I.sum_byte[`BIT_BUSY])
      || (unlisted_fault_flag && !MASK_I.sum_byte[`BIT_UNK]);
  end

  // registered alert pin
  always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ALERT_N_O <= 1'b1;
    end else begin
      ALERT_N_O <= !any_alert;
    end
  end

  // checks on the system clock; the link side is judged by its effects here
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!ARST_N_I);

  // summary registers
  a_word_low_byte: assert property (go && req_hold.cmd == `CMD_SUM_WORD
      |=> rdata_hold[7:0] == $past(sum_byte))
    else $error("word low byte differs from summary byte");
  a_busy_clear: assert property (wr && req_hold.cmd == `CMD_SUM_WORD
      && req_hold.data == `CLR_BUSY_WORD && !EVENT_I.busy |=> !busy)
    else $error("busy not cleared by word write");
  a_busy_byte_clear: assert property (wr && req_hold.cmd == `CMD_SUM_BYTE
      && req_hold.data[7:0] == `CLR_BUSY_BYTE && !EVENT_I.busy |=> !busy)
    else $error("busy not cleared by byte write");
  a_unlisted_fault_flag_clear: assert property (wr && req_hold.cmd == `CMD_SUM_WORD
      && req_hold.data == `CLR_BUSY_UNK_WORD && !EVENT_I.unlisted_fault_flag && !EVENT_I.busy
      |=> !unlisted_fault_flag && !busy)
    else $error("busy or unlisted_fault_flag not cleared");
  a_cml_summary: assert property (sum_byte[1] == |cml)
    else $error("communication_error_flag summary bit wrong");

  // latched detail flags: clears, set-wins and unsupported bits
  a_clear_all: assert property (clr_all && ~|EVENT_I.temp |=> temp == `ZERO8)
    else $error("clear all left a temperature flag");
  a_clear_all_cml: assert property (clr_all && ~|cml_set |=> cml == `ZERO8)
    else $error("clear all left a communication_error_flag flag");
  a_write_one_clear: assert property (wr && req_hold.cmd == `CMD_IOUT
      && ~|EVENT_I.iout |=> (iout & $past(c_iout)) == `ZERO8)
    else $error("write one left a current flag");
  a_zero_write: assert property (wr && req_hold.cmd == `CMD_IOUT
      && req_hold.data[7:0] == `ZERO8
      |=> iout == ($past(iout) | ($past(EVENT_I.iout) & `SUPP_IOUT)))
    else $error("zero write changed current flags");
  a_set_wins: assert property (EVENT_I.vout[`BIT_OVF] |=> vout[`BIT_OVF]
      ##1 (vout[`BIT_OVF] || $past(c_vout[`BIT_OVF])))
    else $error("overvolt fault event lost");
  a_current_flag: assert property (EVENT_I.iout[`BIT_OVF] |=> iout[`BIT_OVF])
    else $error("overcurrent fault event lost");
  a_input_flag: assert property (EVENT_I.inp[`BIT_UVW] |=> inp[`BIT_UVW])
    else $error("input undervolt warning lost");
  a_temp_warn: assert property (EVENT_I.temp[6] |=> temp[6])
    else $error("overtemperature warning lost");
  a_cml_flag: assert property (EVENT_I.cml[3] |=> cml[3])
    else $error("logic core error lost");
  a_unsupported_zero: assert property (vout[1:0] == 2'h0 && temp[5:0] == 6'h0
      && cml[2] == 1'b0 && cml[0] == 1'b0 && sum_word[10] == 1'b0 && sum_word[8] == 1'b0)
    else $error("unsupported bit reads one");
  a_current_input_zero: assert property (iout[6] == 1'b0 && iout[4:0] == 5'h00
      && inp[6] == 1'b0 && inp[4:0] == 5'h00)
    else $error("unsupported current or input bit set");

  // back-channel reporting
  a_follower_communication_error_flag: assert property (live.follower && EVENT_I.backchan_err
      |=> cml[`BIT_COMMUNICATION_ERROR_FLAG])
    else $error("back-channel error not reported");
  a_leader_quiet: assert property (!live.follower && !EVENT_I.cml[`BIT_COMMUNICATION_ERROR_FLAG]
      && !cml[`BIT_COMMUNICATION_ERROR_FLAG] |=> !cml[`BIT_COMMUNICATION_ERROR_FLAG])
    else $error("leader flagged a back-channel error");

  // alert gating
  a_ovf_masked: assert property (MASK_I.vout[`BIT_OVF] || &MASK_I.ext_ovp |-> !ovf_alert)
    else $error("masked overvolt raised alert");
  a_uvw_gated: assert property (!vin_seen_on |-> !uvw_alert)
    else $error("undervolt warning alerted before turn-on");
  a_uvw_alerts: assert property (vin_seen_on && inp[`BIT_UVW] && !MASK_I.inp[`BIT_UVW]
      |-> any_alert)
    else $error("undervolt warning did not alert after turn-on");
  a_low_input_quiet: assert property (live.input_too_low && ~|vout && ~|iout && ~|inp
      && ~|temp && ~|cml && !busy && !unlisted_fault_flag |=> ALERT_N_O)
    else $error("low input raised the alert");
  a_alert_pin: assert property (any_alert |=> !ALERT_N_O ##0 $past(any_alert))
    else $error("alert pin missed unmasked flag");

endmodule : pmbus_fault_status_bank
`default_nettype wire
